// ===== crc_pkg.sv
// shared constants, register map and state type of the chip reset controller
package crc_pkg;
    localparam int CLK_MHZ          = 250;
    localparam int POR_GND_TIME_US  = 100;
    localparam int POR_GND_CYC      = POR_GND_TIME_US * CLK_MHZ;
    localparam int PUT_TIME_MS      = 64;
    localparam int PUT_CYC          = PUT_TIME_MS * 1000 * CLK_MHZ;
    localparam int OSC_CYC          = 1024;
    localparam int GLITCH_CYC       = 8;
    localparam int TMR_W            = 24;

    localparam logic [13:0] CAL_WORD_ADDR = 14'h2008;

    localparam logic [7:0] OFS_PWRSTAT  = 8'h00;
    localparam logic [7:0] OFS_CAUSE    = 8'h04;
    localparam logic [7:0] OFS_INT_STS  = 8'h08;
    localparam logic [7:0] OFS_INT_MASK = 8'h0C;
    localparam logic [7:0] OFS_CTRL     = 8'h10;
    localparam logic [7:0] OFS_RETAIN   = 8'h14;
    localparam logic [7:0] OFS_CAL      = 8'h18;

    // power status field positions
    localparam int BIT_BOR_N = 0;
    localparam int BIT_POR_N = 1;
    localparam int BIT_PD_N  = 3;
    localparam int BIT_TO_N  = 4;

    // interrupt status bits
    localparam int EV_POR      = 0;
    localparam int EV_BOR      = 1;
    localparam int EV_WDT_RUN  = 2;
    localparam int EV_WDT_WAKE = 3;
    localparam int EV_EXT_RUN  = 4;
    localparam int EV_EXT_SLP  = 5;
    localparam int EV_GLITCH   = 6;
    localparam int EV_W        = 7;

    localparam logic [2:0] CAUSE_NONE     = 3'h0;
    localparam logic [2:0] CAUSE_POR      = 3'h1;
    localparam logic [2:0] CAUSE_BOR      = 3'h2;
    localparam logic [2:0] CAUSE_WDT_RUN  = 3'h3;
    localparam logic [2:0] CAUSE_WDT_SLP  = 3'h4;
    localparam logic [2:0] CAUSE_EXT_RUN  = 3'h5;
    localparam logic [2:0] CAUSE_EXT_SLP  = 3'h6;

    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] RETAIN_RST = 8'h00;
    localparam logic [7:0] CAL_RST    = 8'h80;

    typedef enum logic [2:0] {
        ST_POR, ST_BOR, ST_PUT, ST_OSC, ST_WDT, ST_EXT, ST_RUN
    } crc_state_t;
endpackage : crc_pkg

// ===== crc_pin_if.sv
// signals between the reset pin filter and the reset core
`timescale 1ns/1ps
`default_nettype none
interface crc_pin_if;
    logic pin_raw;
    logic enable;
    logic ext_low;
    logic glitch;
    modport filt (input pin_raw, input enable, output ext_low, output glitch);
    modport core (output pin_raw, output enable, input ext_low, input glitch);
endinterface : crc_pin_if
`default_nettype wire

// ===== crc_glitch_filter.sv
// synchroniser and glitch filter for the shared external reset pin
`timescale 1ns/1ps
`default_nettype none
module crc_glitch_filter
    import crc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    crc_pin_if.filt   pin
);
    logic                 sync1_r;
    logic                 sync2_r;
    logic [7:0]           cnt_r;
    logic                 ext_low_r;
    logic                 glitch_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end
        else
        begin
            sync1_r <= pin.pin_raw;
            sync2_r <= sync1_r;
        end
    end

    // count consecutive low cycles; a shorter low is dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r     <= 8'h00;
            ext_low_r <= 1'b0;
            glitch_r  <= 1'b0;
        end
        else if (!pin.enable) // [RULE13]
        begin
            cnt_r     <= 8'h00;
            ext_low_r <= 1'b0;
            glitch_r  <= 1'b0;
        end
        else if (sync2_r)
        begin
            glitch_r  <= !ext_low_r && cnt_r != 8'h00; // [RULE7]
            cnt_r     <= 8'h00;
            ext_low_r <= 1'b0;
        end
        else
        begin
            glitch_r <= 1'b0;
            if (cnt_r == 8'(GLITCH_CYC - 1))
                ext_low_r <= 1'b1; // [RULE19]
            else
                cnt_r <= cnt_r + 8'h01;
        end
    end

    assign pin.ext_low = ext_low_r;
    assign pin.glitch  = glitch_r;

    chk_filter_disabled: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
        !pin.enable |=> !ext_low_r)
        else $error("filtered reset active while pin reset disabled");
    chk_filter_len: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
        $rose(ext_low_r) |-> $past(cnt_r) == 8'(GLITCH_CYC - 1) && !$past(sync2_r))
        else $error("external reset asserted before the low time elapsed");
endmodule : crc_glitch_filter
`default_nettype wire

// ===== crc_top.sv
// chip reset controller: cause tracking, power-up timers, pin filter, apb registers
//
// Overview of operation
// RULE1 - calibration word, program address 2008h, survives bulk erase untouched
// RULE2 - six reset causes told apart: power-on, brown-out, watchdog and pin, run/sleep
// RULE3 - retained registers keep contents through every reset except power-on; here only presetn clears retain_r, a por_trip power-on keeps it
// RULE4 - other registers take reset values on power-on, pin, watchdog, brown-out reset; here only ctrl_r does, mask_r and sts_r clear on presetn alone
// RULE5 - watchdog wake from sleep resumes execution without register reset
// RULE6 - timeout and power-down flags updated per cause so software can tell
// RULE7 - reset pin path filters out short pulses
// RULE8 - power-on reset holds chip until supply-good shows
// RULE9 - with brown-out enabled, hold reset until supply above threshold
// RULE10 - power-on reset ignores falling supply; re-arms after 100 us at ground
// RULE11 - outside circuit holds reset until operating conditions are met
// RULE12 - watchdog reset acts internally, never drives the pin low
// RULE13 - pin-enable 0: reset made internally, pin is no reset input
// RULE14 - pin-enable 1: pin is active-low reset input with weak pull-up
// RULE15 - power-up timer, enabled low, adds 64 ms after power-on or brown-out
// RULE16 - power-up timer starts after power-on, oscillator timer after it
// RULE17 - power-on flag reads 0 after power-on, else kept; software writes 1
// RULE18 - internal reset asserts asynchronously, releases synchronously when all idle; here only presetn and por_trip assert it asynchronously
// RULE19 - pin must stay low a set number of cycles before reset asserts
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module crc_top
    import crc_pkg::*;
#(
    parameter int POR_GND_CYCLES = POR_GND_CYC,
    parameter int PUT_CYCLES     = PUT_CYC
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        supply_good,
    input  wire logic        supply_at_ground,
    input  wire logic        brown_out_ok,
    input  wire logic [1:0]  brown_out_mode,
    input  wire logic        power_up_timer_enable_n,
    input  wire logic        osc_startup_enable,
    input  wire logic        ext_reset_pin_enable,
    input  wire logic        shared_gpio_reset_pin,
    input  wire logic        sleep_active,
    input  wire logic        watchdog_timeout,
    input  wire logic        bulk_erase,
    input  wire logic [7:0]  cal_fuse,
    output logic             core_reset_n,
    output logic             wake_resume,
    output logic             pin_pullup_en,
    output logic [7:0]       osc_trim,
    output logic             irq
);
    crc_pin_if pin ();

    crc_state_t        state_r;
    crc_state_t        state_nxt;
    logic [TMR_W-1:0]  tmr_r;
    logic [TMR_W-1:0]  gnd_cnt_r;
    logic              por_armed_r;
    logic              por_trip;
    logic              bor_trip;
    logic              hold_n;
    logic              wake_ev;
    logic              por_n_r;
    logic              bor_n_r;
    logic              to_n_r;
    logic              pd_n_r;
    logic [2:0]        cause_r;
    logic [EV_W-1:0]   sts_r;
    logic [EV_W-1:0]   mask_r;
    logic [EV_W-1:0]   ev;
    logic [7:0]        ctrl_r;
    logic [7:0]        retain_r;
    logic [7:0]        calib_r;
    logic              cal_loaded_r;
    logic              wr;
    logic [31:0]       rdata;
    logic              hit;

    assign pin.pin_raw = shared_gpio_reset_pin;
    assign pin.enable  = ext_reset_pin_enable;

    crc_glitch_filter u_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (pin.filt)
    );

    // where a hold ends: power-up timer, then oscillator timer, then pin reset while the pin is low, then run
    function automatic crc_state_t after_hold(input logic put_n, input logic osc_en,
                                              input logic ext_low);
        if (!put_n)
            return ST_PUT;
        else if (osc_en)
            return ST_OSC;
        else if (ext_low)
            return ST_EXT;
        return ST_RUN;
    endfunction : after_hold

    assign por_trip = por_armed_r && !supply_good; // [RULE10]
    // mode 10 switches brown-out off in sleep to save current
    assign bor_trip = brown_out_mode[1] && (brown_out_mode[0] || !sleep_active)
                      && !brown_out_ok;
    assign wake_ev  = state_r == ST_RUN && state_nxt == ST_RUN && watchdog_timeout
                      && sleep_active; // [RULE5]

    always_comb
    begin
        state_nxt = state_r;
        if (por_trip)
            state_nxt = ST_POR; // [RULE8]
        else if (bor_trip)
            state_nxt = ST_BOR; // [RULE9]
        else
        begin
            case (state_r)
                ST_POR, ST_BOR:
                    state_nxt = after_hold(power_up_timer_enable_n, osc_startup_enable,
                                           pin.ext_low); // [RULE16]
                ST_PUT:
                    if (tmr_r == TMR_W'(PUT_CYCLES - 1))
                        state_nxt = after_hold(1'b1, osc_startup_enable, pin.ext_low);
                ST_OSC:
                    if (tmr_r == TMR_W'(OSC_CYC - 1))
                        state_nxt = pin.ext_low ? ST_EXT : ST_RUN;
                ST_WDT:
                    state_nxt = ST_RUN;
                ST_EXT:
                    if (!pin.ext_low)
                        state_nxt = ST_RUN;
                ST_RUN:
                    if (pin.ext_low)
                        state_nxt = ST_EXT;
                    else if (watchdog_timeout && !sleep_active)
                        state_nxt = ST_WDT;
                default:
                    state_nxt = ST_POR;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= ST_POR;
        else
            state_r <= state_nxt;
    end

    // one counter serves both timers; restarts on any re-entry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tmr_r <= '0;
        else if (state_nxt != state_r || (state_r != ST_PUT && state_r != ST_OSC))
            tmr_r <= '0;
        else
            tmr_r <= tmr_r + TMR_W'(1); // [RULE15]
    end

    // a falling supply alone never re-arms power-on detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gnd_cnt_r   <= '0;
            por_armed_r <= 1'b1;
        end
        else
        begin
            if (!supply_at_ground)
                gnd_cnt_r <= '0;
            else if (gnd_cnt_r != TMR_W'(POR_GND_CYCLES - 1))
                gnd_cnt_r <= gnd_cnt_r + TMR_W'(1);
            if (supply_at_ground && gnd_cnt_r == TMR_W'(POR_GND_CYCLES - 1))
                por_armed_r <= 1'b1; // [RULE10]
            else if (state_r == ST_POR && supply_good)
                por_armed_r <= 1'b0;
        end
    end

    // watchdog reset only lowers the core reset; the pin has no driver here
    assign hold_n = presetn && !por_trip;
    always_ff @(posedge pclk or negedge hold_n)
    begin
        if (!hold_n)
            core_reset_n <= 1'b0; // [RULE18]
        else
            core_reset_n <= state_nxt == ST_RUN; // [RULE18] [RULE12]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_resume   <= 1'b0;
            pin_pullup_en <= 1'b0;
        end
        else
        begin
            wake_resume   <= wake_ev; // [RULE5]
            pin_pullup_en <= ext_reset_pin_enable; // [RULE14]
        end
    end

    always_comb
    begin
        ev              = '0;
        ev[EV_POR]      = state_nxt == ST_POR && state_r != ST_POR;
        ev[EV_BOR]      = state_nxt == ST_BOR && state_r != ST_BOR;
        ev[EV_WDT_RUN]  = state_nxt == ST_WDT && state_r != ST_WDT;
        ev[EV_WDT_WAKE] = wake_ev;
        ev[EV_EXT_RUN]  = state_nxt == ST_EXT && state_r != ST_EXT && !sleep_active;
        ev[EV_EXT_SLP]  = state_nxt == ST_EXT && state_r != ST_EXT && sleep_active;
        ev[EV_GLITCH]   = pin.glitch;
    end

    assign wr  = psel && penable && pwrite && pready;
    assign hit = paddr == OFS_PWRSTAT || paddr == OFS_CAUSE || paddr == OFS_INT_STS
                 || paddr == OFS_INT_MASK || paddr == OFS_CTRL || paddr == OFS_RETAIN
                 || paddr == OFS_CAL;

    // status flags per cause; a hardware event beats a software write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            por_n_r <= 1'b0;
            bor_n_r <= 1'b1;
            to_n_r  <= 1'b1;
            pd_n_r  <= 1'b1;
            cause_r <= CAUSE_POR;
        end
        else if (ev[EV_POR])
        begin
            por_n_r <= 1'b0; // [RULE17]
            to_n_r  <= 1'b1; // [RULE6]
            pd_n_r  <= 1'b1;
            cause_r <= CAUSE_POR; // [RULE2]
        end
        else if (ev[EV_BOR])
        begin
            bor_n_r <= 1'b0;
            to_n_r  <= 1'b1; // [RULE6]
            pd_n_r  <= 1'b1;
            cause_r <= CAUSE_BOR; // [RULE2]
        end
        else if (ev[EV_WDT_RUN])
        begin
            to_n_r  <= 1'b0; // [RULE6]
            cause_r <= CAUSE_WDT_RUN; // [RULE2]
        end
        else if (ev[EV_WDT_WAKE])
        begin
            to_n_r  <= 1'b0; // [RULE6]
            pd_n_r  <= 1'b0;
            cause_r <= CAUSE_WDT_SLP; // [RULE2]
        end
        else if (ev[EV_EXT_SLP])
        begin
            to_n_r  <= 1'b1; // [RULE6]
            pd_n_r  <= 1'b0;
            cause_r <= CAUSE_EXT_SLP; // [RULE2]
        end
        else if (ev[EV_EXT_RUN])
            cause_r <= CAUSE_EXT_RUN; // [RULE2]
        else if (wr && paddr == OFS_PWRSTAT)
        begin
            por_n_r <= por_n_r | pwdata[BIT_POR_N]; // [RULE17]
            bor_n_r <= bor_n_r | pwdata[BIT_BOR_N];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sts_r  <= '0;
            mask_r <= '0;
            irq    <= 1'b0;
        end
        else
        begin
            if (wr && paddr == OFS_INT_STS)
                sts_r <= (sts_r & ~pwdata[EV_W-1:0]) | ev;
            else
                sts_r <= sts_r | ev;
            if (wr && paddr == OFS_INT_MASK)
                mask_r <= pwdata[EV_W-1:0];
            irq <= |(sts_r & mask_r);
        end
    end

    // ctrl follows the core reset; retain only the cold reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= CTRL_RST;
        else if (!core_reset_n)
            ctrl_r <= CTRL_RST; // [RULE4]
        else if (wr && paddr == OFS_CTRL)
            ctrl_r <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            retain_r <= RETAIN_RST;
        else if (wr && paddr == OFS_RETAIN)
            retain_r <= pwdata[7:0]; // [RULE3]
    end

    // fuse value caught once after release; bulk erase has no path here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            calib_r      <= CAL_RST;
            cal_loaded_r <= 1'b0;
            osc_trim     <= CAL_RST;
        end
        else
        begin
            if (!cal_loaded_r)
            begin
                calib_r      <= cal_fuse; // [RULE1]
                cal_loaded_r <= 1'b1;
            end
            osc_trim <= calib_r;
        end
    end

    always_comb
    begin
        rdata = 32'h0000_0000;
        case (paddr)
            OFS_PWRSTAT:
            begin
                rdata[BIT_POR_N] = por_n_r;
                rdata[BIT_BOR_N] = bor_n_r;
                rdata[BIT_TO_N]  = to_n_r;
                rdata[BIT_PD_N]  = pd_n_r;
            end
            OFS_CAUSE:    rdata = {25'h0, state_r, 1'b0, cause_r};
            OFS_INT_STS:  rdata = {25'h0, sts_r};
            OFS_INT_MASK: rdata = {25'h0, mask_r};
            OFS_CTRL:     rdata = {24'h0, ctrl_r};
            OFS_RETAIN:   rdata = {24'h0, retain_r};
            OFS_CAL:      rdata = {2'h0, CAL_WORD_ADDR, 8'h00, calib_r};
            default:      rdata = 32'h0000_0000;
        endcase
    end

    // answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable)
                prdata <= rdata;
        end
    end

    chk_por_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
        por_trip |=> !core_reset_n)
        else $error("core reset released during power-on hold");
    chk_bor_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
        bor_trip |=> !core_reset_n && state_r inside {ST_POR, ST_BOR})
        else $error("core reset released during brown-out");
    chk_por_rearm: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
        $rose(por_armed_r) |-> $past(gnd_cnt_r) == TMR_W'(POR_GND_CYCLES - 1))
        else $error("power-on detection re-armed too early");
    chk_wake_resume: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
        wake_ev |=> core_reset_n && wake_resume && !to_n_r && !pd_n_r)
        else $error("watchdog wake did not resume cleanly");
    chk_wdt_flags: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        ev[EV_WDT_RUN] |=> !core_reset_n && !to_n_r && cause_r == CAUSE_WDT_RUN)
        else $error("watchdog reset flags wrong");
    chk_por_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
        ev[EV_POR] |=> !por_n_r && to_n_r && pd_n_r)
        else $error("power-on flags wrong");
    chk_ctrl_reset: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
        !core_reset_n |=> ctrl_r == CTRL_RST)
        else $error("control register not reset");
    chk_retain_kept: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
        !core_reset_n && !(wr && paddr == OFS_RETAIN) |=> $stable(retain_r))
        else $error("retained register changed by reset");
    chk_put_order: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
        state_r == ST_POR && state_nxt inside {ST_OSC, ST_RUN, ST_EXT}
        |-> power_up_timer_enable_n)
        else $error("power-up timer skipped");
    chk_put_len: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
        state_r == ST_PUT && state_nxt != ST_PUT && !por_trip && !bor_trip
        |-> tmr_r == TMR_W'(PUT_CYCLES - 1))
        else $error("power-up timer length wrong");
    chk_cal_kept: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
        bulk_erase && cal_loaded_r |=> calib_r == $past(calib_r))
        else $error("calibration word disturbed by erase");
    // the release edge itself is not covered by disable iff, so gate on presetn
    chk_pullup: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
        presetn |=> pin_pullup_en == $past(ext_reset_pin_enable))
        else $error("pull-up does not follow pin enable");

    cov_power_up: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_OSC ##1 state_r == ST_RUN);
    cov_wdt_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_ev);
    cov_ext_sleep: cover property (@(posedge pclk) disable iff (!presetn) ev[EV_EXT_SLP]);
endmodule : crc_top
`default_nettype wire

// ===== crc_pin_partner.sv
// behavioural reset switch on the shared reset pin, with the weak pull-up
`timescale 1ns/1ps
`default_nettype none
module crc_pin_partner
(
    input  wire logic pclk,
    input  wire logic pullup_en,
    input  wire logic press,
    output logic      pin
);
    logic flip_r = 1'b0;
    always_ff @(posedge pclk) flip_r <= ~flip_r;
    // a released pin without pull-up floats, so show a level that keeps changing
    assign pin = press ? 1'b0 : (pullup_en ? 1'b1 : flip_r);
endmodule : crc_pin_partner
`default_nettype wire

// ===== crc_top_tb.sv
// self-checking bench for the chip reset controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module crc_top_tb
    import crc_pkg::*;
;
    localparam int PG = 20;
    localparam int PW = 50;
    localparam int SEQ = PW + OSC_CYC;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, rerr, irq, press;
    logic        supply_good, supply_at_ground, brown_out_ok, power_up_timer_enable_n;
    logic        osc_startup_enable, ext_reset_pin_enable, pin, sleep_active;
    logic        watchdog_timeout, bulk_erase, core_reset_n, wake_resume, pin_pullup_en;
    logic [1:0]  brown_out_mode;
    logic [7:0]  paddr, cal_fuse, osc_trim;
    logic [31:0] pwdata, prdata, rdat;
    int          failures, cmp_count, rst_cyc, wake_cnt, r0, n;

    always #2 pclk = ~pclk;
    always @(posedge pclk) if (core_reset_n === 1'b0) rst_cyc <= rst_cyc + 1;
    always @(posedge pclk) if (wake_resume === 1'b1) wake_cnt <= wake_cnt + 1;

    crc_top #(.POR_GND_CYCLES(PG), .PUT_CYCLES(PW)) u_crc_top (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_good,
        .supply_at_ground, .brown_out_ok, .brown_out_mode, .power_up_timer_enable_n,
        .osc_startup_enable, .ext_reset_pin_enable, .shared_gpio_reset_pin(pin),
        .sleep_active, .watchdog_timeout, .bulk_erase, .cal_fuse, .core_reset_n,
        .wake_resume, .pin_pullup_en, .osc_trim, .irq);
    crc_pin_partner u_crc_pin_partner (.pclk, .pullup_en(pin_pullup_en), .press, .pin);

    task automatic tick(input int c);
        repeat (c) @(posedge pclk);
    endtask : tick

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e & m, rdat & m)
    endtask : rd

    function automatic logic [31:0] ps(input int t, d, p, b);
        return {27'h0, 1'(t), 1'(d), 1'b0, 1'(p), 1'(b)};
    endfunction : ps

    task automatic wait_up(input int lim);
        n = 0;
        while (core_reset_n !== 1'b1 && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK("released", 1'b1, core_reset_n)
    endtask : wait_up

    task automatic hold_pin(input int c);
        press <= 1'b1;
        tick(c);
        press <= 1'b0;
    endtask : hold_pin

    task automatic wdt_pulse;
        watchdog_timeout <= 1'b1;
        tick(1);
        watchdog_timeout <= 1'b0;
        tick(6);
    endtask : wdt_pulse

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    initial
    begin
        #80000;
        failures++;
        give_verdict();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, press} = '0;
        {supply_good, supply_at_ground, brown_out_mode, power_up_timer_enable_n} = '0;
        {sleep_active, watchdog_timeout, bulk_erase} = '0;
        {brown_out_ok, osc_startup_enable, ext_reset_pin_enable} = 3'h7;
        cal_fuse = 8'h3C;
        tick(16);
        presetn <= 1'b1;
        tick(5);
        `CHK("held low", 1'b0, core_reset_n)
        supply_good <= 1'b1;
        wait_up(2000);
        `CHK("por delay", 1'b1, n inside {[SEQ:SEQ + 8]})
        rd(OFS_PWRSTAT, 32'h1A, ps(1, 1, 0, 0), "status");
        rd(OFS_CAUSE, 32'h7, 32'(CAUSE_POR), "cause");
        rd(OFS_CAL, 32'h3FFF_00FF, {2'h0, CAL_WORD_ADDR, 8'h00, cal_fuse}, "cal");
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {rerr, rdat})
        apb(1'b1, OFS_PWRSTAT, 32'h3);
        apb(1'b1, OFS_RETAIN, 32'hA5);
        apb(1'b1, OFS_CTRL, 32'h5A);
        bulk_erase <= 1'b1;
        tick(1);
        bulk_erase <= 1'b0;
        rd(OFS_CAL, 32'hFF, 32'(cal_fuse), "cal kept");
        `CHK("trim", cal_fuse, osc_trim)
        $display("test power_on done");
        wdt_pulse();
        rd(OFS_CAUSE, 32'h7, 32'(CAUSE_WDT_RUN), "cause");
        rd(OFS_PWRSTAT, 32'h1B, ps(0, 1, 1, 1), "status");
        rd(OFS_RETAIN, 32'hFF, 32'hA5, "retain");
        rd(OFS_CTRL, 32'hFF, 32'h0, "ctrl");
        rd(OFS_INT_STS, 32'h4, 32'h4, "int sts");
        apb(1'b1, OFS_INT_MASK, 32'h4);
        tick(3);
        `CHK("irq set", 1'b1, irq)
        apb(1'b1, OFS_INT_STS, 32'h7F);
        tick(3);
        `CHK("irq clear", 1'b0, irq)
        $display("test watchdog_run done");
        apb(1'b1, OFS_CTRL, 32'h5A);
        r0 = rst_cyc;
        sleep_active <= 1'b1;
        wdt_pulse();
        sleep_active <= 1'b0;
        `CHK("wake pulse", 1, wake_cnt)
        `CHK("no reset", r0, rst_cyc)
        rd(OFS_CTRL, 32'hFF, 32'h5A, "ctrl kept");
        rd(OFS_CAUSE, 32'h7, 32'(CAUSE_WDT_SLP), "cause");
        rd(OFS_PWRSTAT, 32'h1B, ps(0, 0, 1, 1), "status");
        $display("test watchdog_wake done");
        `CHK("pullup", 1'b1, pin_pullup_en)
        hold_pin(4);
        tick(12);
        `CHK("glitch", r0, rst_cyc)
        rd(OFS_INT_STS, 32'h40, 32'h40, "glitch sts");
        hold_pin(20);
        wait_up(50);
        rd(OFS_CAUSE, 32'h7, 32'(CAUSE_EXT_RUN), "cause");
        rd(OFS_CTRL, 32'hFF, 32'h0, "ctrl");
        sleep_active <= 1'b1;
        hold_pin(20);
        sleep_active <= 1'b0;
        wait_up(50);
        rd(OFS_CAUSE, 32'h7, 32'(CAUSE_EXT_SLP), "cause");
        rd(OFS_PWRSTAT, 32'h1B, ps(1, 0, 1, 1), "status");
        ext_reset_pin_enable <= 1'b0;
        tick(2);
        `CHK("no pullup", 1'b0, pin_pullup_en)
        r0 = rst_cyc;
        hold_pin(20);
        tick(5);
        `CHK("pin off", r0, rst_cyc)
        ext_reset_pin_enable <= 1'b1;
        $display("test pin done");
        brown_out_mode <= 2'h2;
        brown_out_ok <= 1'b0;
        sleep_active <= 1'b1;
        r0 = rst_cyc;
        tick(5);
        `CHK("bor sleep", r0, rst_cyc)
        sleep_active <= 1'b0;
        brown_out_mode <= 2'h3;
        tick(5);
        `CHK("bor held", 1'b0, core_reset_n)
        brown_out_ok <= 1'b1;
        wait_up(2000);
        `CHK("bor delay", 1'b1, n inside {[SEQ:SEQ + 8]})
        rd(OFS_PWRSTAT, 32'h1B, ps(1, 1, 1, 0), "status");
        rd(OFS_CAUSE, 32'h7, 32'(CAUSE_BOR), "cause");
        $display("test brown_out done");
        brown_out_mode <= 2'h0;
        r0 = rst_cyc;
        supply_good <= 1'b0;
        tick(10);
        `CHK("falling", r0, rst_cyc)
        supply_at_ground <= 1'b1;
        tick(PG + 5);
        supply_at_ground <= 1'b0;
        tick(2);
        `CHK("rearmed", 1'b0, core_reset_n)
        supply_good <= 1'b1;
        wait_up(2000);
        rd(OFS_PWRSTAT, 32'h1A, ps(1, 1, 0, 0), "status");
        $display("test rearm done");
        give_verdict();
    end
endmodule : crc_top_tb
`default_nettype wire
